// >>> rtl/gpt_defines.svh
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

// Register byte addresses
`define GPT_T0_RELOAD_ADDR  32'hFFFF0300
`define GPT_T0_COUNT_ADDR   32'hFFFF0304
`define GPT_T0_CTRL_ADDR    32'hFFFF0308
`define GPT_T0_CLR_ADDR     32'hFFFF030C
`define GPT_T1_RELOAD_ADDR  32'hFFFF0320
`define GPT_T1_COUNT_ADDR   32'hFFFF0324
`define GPT_T1_CTRL_ADDR    32'hFFFF0328
`define GPT_T1_CLR_ADDR     32'hFFFF032C
`define GPT_T1_CAP_ADDR     32'hFFFF0330
`define GPT_STATUS_ADDR     32'hFFFF0334

// Reset values
`define GPT_T0_RELOAD_RST   16'h0000
`define GPT_T0_COUNT_RST    16'hFFFF
`define GPT_T1_RELOAD_RST   32'h00000000
`define GPT_T1_COUNT_RST    32'h0FFFFFFF
`define GPT_CTRL_RST        32'h00000000
`define GPT_T1_CAP_RST      32'h00000000

// Control field positions
`define GPT_EN_BIT          7
`define GPT_MODE_BIT        6
`define GPT_T0_PRE_LSB      2
`define GPT_T1_PRE_LSB      0
`define GPT_T1_FMT_LSB      4
`define GPT_T1_UP_BIT       8
`define GPT_T1_CLK_LSB      9
`define GPT_T1_EVT_LSB      12
`define GPT_T1_CAPEN_BIT    17
`define GPT_T0_CTRL_MASK    32'h000000CC
`define GPT_T1_CTRL_MASK    32'h0003FFFF

// Capture event numbering offset
`define GPT_EVT_OFFSET      6'h02

// Prescaler terminal counts
`define GPT_DIV1_LIM        15'h0000
`define GPT_DIV16_LIM       15'h000F
`define GPT_DIV256_LIM      15'h00FF
`define GPT_DIV32K_LIM      15'h7FFF

// Time-of-day field limits
`define GPT_HUND_MAX        8'h63
`define GPT_MINSEC_MAX      8'h3B
`define GPT_HR23_MAX        8'h17
`define GPT_HR255_MAX       8'hFF

// AXI responses
`define GPT_RESP_OKAY       2'h0
`define GPT_RESP_SLVERR     2'h2

`endif

// >>> rtl/gpt_pkg.sv
`default_nettype none
package gpt_pkg;

  typedef enum logic [2:0] {
    GPT_SRC_CORE   = 3'b000,
    GPT_SRC_XTAL   = 3'b001,
    GPT_SRC_GPIO_A = 3'b010,
    GPT_SRC_GPIO_B = 3'b011
  } gpt_clksel_e;

  typedef enum logic [1:0] {
    GPT_FMT_BIN    = 2'b00,
    GPT_FMT_RSVD   = 2'b01,
    GPT_FMT_TIME23 = 2'b10,
    GPT_FMT_TIME255 = 2'b11
  } gpt_fmt_e;

  typedef enum logic [1:0] {
    GPT_T0_DIV1   = 2'b00,
    GPT_T0_DIV16  = 2'b01,
    GPT_T0_DIV256 = 2'b10,
    GPT_T0_DIVX   = 2'b11
  } gpt_t0_pre_e;

  typedef enum logic [3:0] {
    GPT_T1_DIV1   = 4'b0000,
    GPT_T1_DIV16  = 4'b0100,
    GPT_T1_DIV256 = 4'b1000,
    GPT_T1_DIV32K = 4'b1111
  } gpt_t1_pre_e;

endpackage
`default_nettype wire

// >>> rtl/gpt_timers.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "gpt_defines.svh"

module gpt_timers
  import gpt_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        xtal_32k_in,
  input  wire logic        gpio_count_input_a,
  input  wire logic        gpio_count_input_b,
  input  wire logic [31:0] irq_source_in,
  output logic             t0_irq,
  output logic             t1_irq,
  output logic             t0_adc_trig,
  output logic             t1_adc_trig
);

  // Packed time step: [31:24] h, [23:16] m, [15:8] s, [7:0] hundredths
  function automatic logic [31:0] tm_step(input logic [31:0] v,
                                          input logic        up,
                                          input logic [7:0]  hmax);
    logic [7:0] h;
    logic [7:0] m;
    logic [7:0] s;
    logic [7:0] c;
    h = v[31:24];
    m = v[23:16];
    s = v[15:8];
    c = v[7:0];
    if (up)
    begin
      if (c < `GPT_HUND_MAX) c = c + 8'h01;
      else
      begin
        c = 8'h00;
        if (s < `GPT_MINSEC_MAX) s = s + 8'h01;
        else
        begin
          s = 8'h00;
          if (m < `GPT_MINSEC_MAX) m = m + 8'h01;
          else
          begin
            m = 8'h00;
            h = (h < hmax) ? h + 8'h01 : 8'h00;
          end
        end
      end
    end
    else
    begin
      if (c != 8'h00) c = c - 8'h01;
      else
      begin
        c = `GPT_HUND_MAX;
        if (s != 8'h00) s = s - 8'h01;
        else
        begin
          s = `GPT_MINSEC_MAX;
          if (m != 8'h00) m = m - 8'h01;
          else
          begin
            m = `GPT_MINSEC_MAX;
            h = (h != 8'h00) ? h - 8'h01 : hmax;
          end
        end
      end
    end
    return {h, m, s, c};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // Registers
  logic [15:0] t0_reload_reg;
  logic [15:0] t0_cnt_reg;
  logic [31:0] t0_ctrl_reg;
  logic [14:0] t0_pre_reg;
  logic        t0_irq_reg;
  logic        t0_trig_reg;
  logic [31:0] t1_reload_reg;
  logic [31:0] t1_cnt_reg;
  logic [31:0] t1_ctrl_reg;
  logic [31:0] t1_cap_reg;
  logic [14:0] t1_pre_reg;
  logic        t1_irq_reg;
  logic        t1_trig_reg;
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [2:0]  sync3_reg;
  logic [31:0] src_prev_reg;
  logic [31:0] aw_addr_reg;
  logic        aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_full_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // Bus handshakes and write decode
  wire ar_fire  = s_axi_arvalid & s_axi_arready;
  wire wr_fire  = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire wa_timer0_reload_value  = aw_addr_reg == `GPT_T0_RELOAD_ADDR;
  wire wa_timer0_current_count = aw_addr_reg == `GPT_T0_COUNT_ADDR;
  wire wa_timer0_control = aw_addr_reg == `GPT_T0_CTRL_ADDR;
  wire wa_t0clr = aw_addr_reg == `GPT_T0_CLR_ADDR;
  wire wa_timer1_reload_value  = aw_addr_reg == `GPT_T1_RELOAD_ADDR;
  wire wa_timer1_current_count = aw_addr_reg == `GPT_T1_COUNT_ADDR;
  wire wa_timer1_control = aw_addr_reg == `GPT_T1_CTRL_ADDR;
  wire wa_t1clr = aw_addr_reg == `GPT_T1_CLR_ADDR;
  wire wa_timer1_capture_value = aw_addr_reg == `GPT_T1_CAP_ADDR;
  wire wa_stat  = aw_addr_reg == `GPT_STATUS_ADDR;
  wire wa_hit   = wa_timer0_reload_value | wa_timer0_current_count | wa_timer0_control | wa_t0clr | wa_timer1_reload_value
                | wa_timer1_current_count | wa_timer1_control | wa_t1clr | wa_timer1_capture_value | wa_stat;
  wire [31:0] wr_timer0_reload_value  = merge({16'h0000, t0_reload_reg}, w_data_reg,
                               w_strb_reg);
  wire [31:0] wr_timer0_control = merge(t0_ctrl_reg, w_data_reg, w_strb_reg)
                       & `GPT_T0_CTRL_MASK;
  wire [31:0] wr_timer1_control = merge(t1_ctrl_reg, w_data_reg, w_strb_reg)
                       & `GPT_T1_CTRL_MASK;

  // Timer0 control fields
  wire          t0_en    = t0_ctrl_reg[`GPT_EN_BIT];
  wire          t0_per   = t0_ctrl_reg[`GPT_MODE_BIT];
  gpt_t0_pre_e  t0_pre_code;
  assign t0_pre_code = gpt_t0_pre_e'(t0_ctrl_reg[`GPT_T0_PRE_LSB +: 2]);
  wire [14:0] t0_lim = (t0_pre_code == GPT_T0_DIV16)  ? `GPT_DIV16_LIM :
                       (t0_pre_code == GPT_T0_DIV256) ? `GPT_DIV256_LIM :
                       `GPT_DIV1_LIM;
  wire t0_start = wr_fire & wa_timer0_control & wr_timer0_control[`GPT_EN_BIT] & ~t0_en;
  wire t0_tick  = t0_en & (t0_pre_reg == t0_lim);
  wire [15:0] t0_step = t0_cnt_reg - 16'h0001;
  wire t0_evt = t0_tick & (t0_step == 16'h0000);

  // Timer1 control fields
  wire          t1_en    = t1_ctrl_reg[`GPT_EN_BIT];
  wire          t1_per   = t1_ctrl_reg[`GPT_MODE_BIT];
  wire          t1_up    = t1_ctrl_reg[`GPT_T1_UP_BIT];
  gpt_fmt_e     t1_fmt;
  gpt_clksel_e  t1_src;
  gpt_t1_pre_e  t1_pre_code;
  assign t1_fmt = gpt_fmt_e'(t1_ctrl_reg[`GPT_T1_FMT_LSB +: 2]);
  assign t1_src = gpt_clksel_e'(t1_ctrl_reg[`GPT_T1_CLK_LSB +: 3]);
  assign t1_pre_code = gpt_t1_pre_e'(t1_ctrl_reg[`GPT_T1_PRE_LSB +: 4]);
  wire [14:0] t1_lim = (t1_pre_code == GPT_T1_DIV16)  ? `GPT_DIV16_LIM :
                       (t1_pre_code == GPT_T1_DIV256) ? `GPT_DIV256_LIM :
                       (t1_pre_code == GPT_T1_DIV32K) ? `GPT_DIV32K_LIM :
                       `GPT_DIV1_LIM;

  // Synchronised rising edges of the pin sources
  wire [2:0] pin_rise = sync2_reg & ~sync3_reg;
  wire t1_src_edge = (t1_src == GPT_SRC_CORE)   ? 1'b1 :
                     (t1_src == GPT_SRC_XTAL)   ? pin_rise[0] :
                     (t1_src == GPT_SRC_GPIO_A) ? pin_rise[1] :
                     (t1_src == GPT_SRC_GPIO_B) ? pin_rise[2] :
                     1'b0;
  wire t1_start = wr_fire & wa_timer1_control & wr_timer1_control[`GPT_EN_BIT] & ~t1_en;
  wire t1_tick  = t1_en & t1_src_edge & (t1_pre_reg == t1_lim);
  wire t1_time  = t1_fmt[1];
  wire [7:0]  t1_hmax = (t1_fmt == GPT_FMT_TIME23) ? `GPT_HR23_MAX
                                                   : `GPT_HR255_MAX;
  wire [31:0] t1_full = t1_time ? {t1_hmax, `GPT_MINSEC_MAX,
                                   `GPT_MINSEC_MAX, `GPT_HUND_MAX}
                                : 32'hFFFFFFFF;
  wire [31:0] t1_term = t1_up ? t1_full : 32'h00000000;
  wire [31:0] t1_wrap = t1_up ? 32'h00000000 : t1_full;
  wire [31:0] t1_step = t1_time ? tm_step(t1_cnt_reg, t1_up, t1_hmax) :
                        t1_up ? t1_cnt_reg + 32'h00000001 :
                        t1_cnt_reg - 32'h00000001;
  wire t1_at_term = t1_cnt_reg == t1_term;
  wire t1_evt = t1_tick & ~t1_at_term & (t1_step == t1_term);

  // Capture source select, event number plus offset
  wire [5:0] cap_idx = {1'b0, t1_ctrl_reg[`GPT_T1_EVT_LSB +: 5]}
                     + `GPT_EVT_OFFSET;
  wire [31:0] src_rise = irq_source_in & ~src_prev_reg;
  wire cap_evt = t1_ctrl_reg[`GPT_T1_CAPEN_BIT] & ~cap_idx[5]
               & src_rise[cap_idx[4:0]];

  // Read decode
  wire ra_timer0_reload_value  = s_axi_araddr == `GPT_T0_RELOAD_ADDR;
  wire ra_timer0_current_count = s_axi_araddr == `GPT_T0_COUNT_ADDR;
  wire ra_timer0_control = s_axi_araddr == `GPT_T0_CTRL_ADDR;
  wire ra_t0clr = s_axi_araddr == `GPT_T0_CLR_ADDR;
  wire ra_timer1_reload_value  = s_axi_araddr == `GPT_T1_RELOAD_ADDR;
  wire ra_timer1_current_count = s_axi_araddr == `GPT_T1_COUNT_ADDR;
  wire ra_timer1_control = s_axi_araddr == `GPT_T1_CTRL_ADDR;
  wire ra_t1clr = s_axi_araddr == `GPT_T1_CLR_ADDR;
  wire ra_timer1_capture_value = s_axi_araddr == `GPT_T1_CAP_ADDR;
  wire ra_stat  = s_axi_araddr == `GPT_STATUS_ADDR;
  wire ra_hit   = ra_timer0_reload_value | ra_timer0_current_count | ra_timer0_control | ra_t0clr | ra_timer1_reload_value
                | ra_timer1_current_count | ra_timer1_control | ra_t1clr | ra_timer1_capture_value | ra_stat;
  wire [31:0] rd_mux =
      ra_timer0_reload_value  ? {16'h0000, t0_reload_reg} :
      ra_timer0_current_count ? {16'h0000, t0_cnt_reg} :
      ra_timer0_control ? t0_ctrl_reg :
      ra_timer1_reload_value  ? t1_reload_reg :
      ra_timer1_current_count ? t1_cnt_reg :
      ra_timer1_control ? t1_ctrl_reg :
      ra_timer1_capture_value ? t1_cap_reg :
      ra_stat  ? {30'h0000000, t1_irq_reg, t0_irq_reg} :
      32'h00000000;

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign t0_irq        = t0_irq_reg;
  assign t1_irq        = t1_irq_reg;
  assign t0_adc_trig   = t0_trig_reg;
  assign t1_adc_trig   = t1_trig_reg;

  // AXI write channel
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `GPT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_reg)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_fire) aw_full_reg <= 1'b0;
      if (s_axi_wvalid && !w_full_reg)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_fire) w_full_reg <= 1'b0;
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wa_hit ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
      end
      else if (s_axi_bready) bvalid_reg <= 1'b0;
    end
  end

  // AXI read channel
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `GPT_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= ra_hit ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
    end
    else if (s_axi_rready) rvalid_reg <= 1'b0;
  end

  // Pin synchronisers and capture edge history
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg    <= 3'h0;
      sync2_reg    <= 3'h0;
      sync3_reg    <= 3'h0;
      src_prev_reg <= 32'hFFFFFFFF;
    end
    else
    begin
      sync1_reg <= {gpio_count_input_b, gpio_count_input_a, xtal_32k_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      src_prev_reg <= irq_source_in;
    end
  end

  // Timer0
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      t0_reload_reg <= `GPT_T0_RELOAD_RST;
      t0_ctrl_reg   <= `GPT_CTRL_RST;
      t0_cnt_reg    <= `GPT_T0_COUNT_RST;
      t0_pre_reg    <= 15'h0000;
      t0_irq_reg    <= 1'b0;
      t0_trig_reg   <= 1'b0;
    end
    else
    begin
      if (wr_fire && wa_timer0_reload_value) t0_reload_reg <= wr_timer0_reload_value[15:0];
      if (wr_fire && wa_timer0_control) t0_ctrl_reg <= wr_timer0_control;
      if (t0_start)
      begin
        t0_pre_reg <= 15'h0000;
        if (wr_timer0_control[`GPT_MODE_BIT]) t0_cnt_reg <= t0_reload_reg;
      end
      else if (t0_en)
      begin
        t0_pre_reg <= t0_tick ? 15'h0000 : t0_pre_reg + 15'h0001;
        if (t0_tick)
        begin
          if (t0_per && t0_evt) t0_cnt_reg <= t0_reload_reg;
          else t0_cnt_reg <= t0_step;
        end
      end
      t0_trig_reg <= t0_evt;
      if (t0_evt) t0_irq_reg <= 1'b1;
      else if (wr_fire && wa_t0clr) t0_irq_reg <= 1'b0;
    end
  end

  // Timer1
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      t1_reload_reg <= `GPT_T1_RELOAD_RST;
      t1_ctrl_reg   <= `GPT_CTRL_RST;
      t1_cnt_reg    <= `GPT_T1_COUNT_RST;
      t1_cap_reg    <= `GPT_T1_CAP_RST;
      t1_pre_reg    <= 15'h0000;
      t1_irq_reg    <= 1'b0;
      t1_trig_reg   <= 1'b0;
    end
    else
    begin
      if (wr_fire && wa_timer1_reload_value)
        t1_reload_reg <= merge(t1_reload_reg, w_data_reg, w_strb_reg);
      if (wr_fire && wa_timer1_control) t1_ctrl_reg <= wr_timer1_control;
      if (cap_evt) t1_cap_reg <= t1_cnt_reg;
      else if (wr_fire && wa_timer1_capture_value)
        t1_cap_reg <= merge(t1_cap_reg, w_data_reg, w_strb_reg);
      if (t1_start)
      begin
        t1_pre_reg <= 15'h0000;
        if (wr_timer1_control[`GPT_MODE_BIT]) t1_cnt_reg <= t1_reload_reg;
      end
      else if (t1_en && t1_src_edge)
      begin
        t1_pre_reg <= t1_tick ? 15'h0000 : t1_pre_reg + 15'h0001;
        if (t1_tick)
        begin
          if (t1_per && t1_evt) t1_cnt_reg <= t1_reload_reg;
          else if (t1_at_term) t1_cnt_reg <= t1_wrap;
          else t1_cnt_reg <= t1_step;
        end
      end
      t1_trig_reg <= t1_evt;
      if (t1_evt) t1_irq_reg <= 1'b1;
      else if (wr_fire && wa_t1clr) t1_irq_reg <= 1'b0;
    end
  end

  // Checks
  chk_t0_irq_set: assert property (@(posedge mclk)
    disable iff (!rstn) t0_evt |=> t0_irq_reg && t0_trig_reg)
    else $error("Timer0 flag not set at zero");
  chk_t0_irq_clear: assert property (@(posedge mclk)
    disable iff (!rstn) wr_fire && wa_t0clr && !t0_evt |=> !t0_irq_reg)
    else $error("Timer0 flag not cleared by write");
  chk_t0_div16: assert property (@(posedge mclk)
    disable iff (!rstn) t0_tick && t0_pre_code == GPT_T0_DIV16
      && !wr_fire |=> (!t0_tick)[*8])
    else $error("Timer0 divide by 16 ticked early");
  chk_t0_free_wrap: assert property (@(posedge mclk)
    disable iff (!rstn) t0_tick && !t0_per && t0_cnt_reg == 16'h0000
      && !wr_fire |=> t0_cnt_reg == 16'hFFFF)
    else $error("Timer0 free mode did not wrap");
  chk_t0_reload: assert property (@(posedge mclk)
    disable iff (!rstn) t0_evt && t0_per && !wr_fire
      |=> t0_cnt_reg == $past(t0_reload_reg))
    else $error("Timer0 periodic reload wrong");
  chk_t0_halt: assert property (@(posedge mclk)
    disable iff (!rstn) !t0_en && !t0_start
      |=> $stable(t0_cnt_reg) && !t0_trig_reg)
    else $error("Timer0 moved while disabled");
  chk_t1_up_wrap: assert property (@(posedge mclk)
    disable iff (!rstn) t1_tick && t1_up && !t1_time && !t1_per
      && t1_at_term && !wr_fire |=> t1_cnt_reg == 32'h00000000)
    else $error("Timer1 up count did not wrap");
  chk_t1_irq_set: assert property (@(posedge mclk)
    disable iff (!rstn) t1_evt |=> t1_irq_reg && t1_trig_reg
      ##1 t1_trig_reg == $past(t1_evt))
    else $error("Timer1 flag or trigger wrong");
  chk_t1_capture: assert property (@(posedge mclk)
    disable iff (!rstn) cap_evt |=> t1_cap_reg == $past(t1_cnt_reg))
    else $error("Timer1 capture value wrong");
  chk_bus_resp: assert property (@(posedge mclk)
    disable iff (!rstn) wr_fire |=> s_axi_bvalid)
    else $error("Write response missing");

  cov_t0_periodic: cover property (@(posedge mclk) disable iff (!rstn)
    t0_evt && t0_per);
  cov_t1_time_evt: cover property (@(posedge mclk) disable iff (!rstn)
    t1_evt && t1_time);
  cov_t1_capture: cover property (@(posedge mclk) disable iff (!rstn)
    cap_evt);
  cov_read_running: cover property (@(posedge mclk) disable iff (!rstn)
    ar_fire && ra_timer1_current_count && t1_en);

endmodule // gpt_timers
`default_nettype wire

// >>> verification/gpt_tb.sv
`timescale 1ns/100ps
`default_nettype none

module testbench
  import gpt_pkg::*;
;
  logic        mclk, rstn, awv, wv, bry, arv, rry, sel;
  logic [2:0]  pin;
  logic [3:0]  ws;
  logic [31:0] awa, wd, ara, src;
  logic [1:0]  r;
  wire logic   awr, wr, bv, arr, rv, i0, i1, tg0, tg1;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rd;
  wire logic   trg = sel ? tg1 : tg0;
  wire logic   irq = sel ? i1 : i0;
  int          num_errors, checks_done;

  gpt_timers dut (
    .mclk(mclk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .xtal_32k_in(pin[0]),
    .gpio_count_input_a(pin[1]), .gpio_count_input_b(pin[2]),
    .irq_source_in(src), .t0_irq(i0), .t1_irq(i1),
    .t0_adc_trig(tg0), .t1_adc_trig(tg1)
  );

  always #2.5 mclk = ~mclk;

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic to_fail();
    $display("ERROR at %0t: wait timed out", $time);
    num_errors++;
    summarize();
  endtask

  // Master holds each channel until the slave's ready, or bvalid/rvalid for the B and R channels, is sampled high
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    logic [2:0] p;
    logic [2:0] t;
    p = 3'b111;
    @(posedge mclk);
    awa <= a;
    wd <= d;
    {bry, wv, awv} <= p;
    for (int n = 0; n < 50 && p != 3'b000; n++)
    begin
      @(negedge mclk);
      t = p & {bv, wr, awr};
      if (t[2])
        r = br;
      @(posedge mclk);
      p = p & ~t;
      {bry, wv, awv} <= p;
    end
    if (p != 3'b000)
      to_fail();
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] d);
    logic [1:0] p;
    logic [1:0] t;
    p = 2'b11;
    @(posedge mclk);
    ara <= a;
    {rry, arv} <= p;
    for (int n = 0; n < 50 && p != 2'b00; n++)
    begin
      @(negedge mclk);
      t = p & {rv, arr};
      if (t[1])
      begin
        d = rd;
        r = rr;
      end
      @(posedge mclk);
      p = p & ~t;
      {rry, arv} <= p;
    end
    if (p != 2'b00)
      to_fail();
  endtask

  task automatic rdck(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axr(a, d);
    check(d, exp);
    check(r, 2'h0);
  endtask

  // Cycles from one trigger pulse to the next
  task automatic trig_gap(output int g);
    int n;
    @(negedge mclk);
    for (n = 0; n < 2000 && trg !== 1'b1; n++)
      @(negedge mclk);
    if (n >= 2000)
      to_fail();
    check(irq, 1'b1);
    @(negedge mclk);
    check(trg, 1'b0);
    for (g = 1; g < 2000 && trg !== 1'b1; g++)
      @(negedge mclk);
  endtask

  task automatic t_reset();
    logic [7:0]  off [8] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h24, 8'h28,
                             8'h30, 8'h34};
    logic [31:0] ex [8] = '{32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0FFFFFFF,
                            32'h0, 32'h0, 32'h0};
    logic [31:0] d;
    for (int i = 0; i < 8; i++)
      rdck({24'hFFFF03, off[i]}, ex[i]);
    axw(32'hFFFF0304, 32'h1234);
    rdck(32'hFFFF0304, 32'hFFFF);
    axr(32'hFFFF0338, d);
    check(d, 32'h0);
    check(r, 2'h2);
    axw(32'hFFFF0338, 32'h0);
    check(r, 2'h2);
  endtask

  task automatic t_intervals();
    logic        tm [7] = '{0, 0, 0, 0, 1, 1, 1};
    logic [31:0] cf [7] = '{32'hC0, 32'hC4, 32'hC8, 32'hCC, 32'hC4,
                            32'hC8, 32'h1C0};
    logic [31:0] rl [7] = '{5, 3, 2, 3, 2, 1, 32'hFFFFFFF0};
    int          gp [7] = '{5, 48, 512, 3, 32, 256, 15};
    logic [31:0] b;
    int          g;
    for (int i = 0; i < 7; i++)
    begin
      sel = tm[i];
      b = tm[i] ? 32'hFFFF0320 : 32'hFFFF0300;
      axw(b, rl[i]);
      axw(b + 8, 32'h0);
      axw(b + 8, cf[i]);
      rdck(b + 8, cf[i]);
      trig_gap(g);
      check(g, gp[i]);
      axw(b + 8, 32'h0);
      check(irq, 1'b1);
      rdck(32'hFFFF0334, {30'h0, tm[i], !tm[i]});
      axw(b + 12, i);
      check(irq, 1'b0);
    end
  endtask

  task automatic t_free_down();
    axw(32'hFFFF0300, 32'h1);
    axw(32'hFFFF0308, 32'hC8);
    axw(32'hFFFF0308, 32'h88);
    // Two ticks of 256 cycles: onto zero, then wrap
    repeat (600) @(posedge mclk);
    rdck(32'hFFFF0304, 32'hFFFF);
    axw(32'hFFFF0308, 32'h0);
    axw(32'hFFFF030C, 32'h0);
  endtask

  // One rising edge on a count pin, wide enough for the synchroniser
  task automatic pulse(input int k);
    pin <= 3'b001 << k;
    repeat (6) @(posedge mclk);
    pin <= 3'b000;
    repeat (6) @(posedge mclk);
  endtask

  task automatic t_sources();
    logic [31:0] c;
    for (int k = 0; k < 3; k++)
    begin
      c = (k + 1) << 9;
      axw(32'hFFFF0320, 32'hFFFFFFFE);
      axw(32'hFFFF0328, 32'h0);
      axw(32'hFFFF0328, c | 32'h1C0);
      axw(32'hFFFF0328, c | 32'h180);
      rdck(32'hFFFF0324, 32'hFFFFFFFE);
      repeat (2) pulse(k);
      rdck(32'hFFFF0324, 32'h0);
      rdck(32'hFFFF0324, 32'h0);
      check(i1, 1'b1);
      axw(32'hFFFF032C, 32'hFF);
      rdck(32'hFFFF0334, 32'h0);
    end
  endtask

  task automatic t_capture();
    logic [31:0] c;
    axw(32'hFFFF0320, 32'h00ABCDEF);
    axw(32'hFFFF0328, 32'h0);
    axw(32'hFFFF0328, 32'hC0);
    axw(32'hFFFF0328, 32'h23000);
    axr(32'hFFFF0324, c);
    src <= 32'h8;
    repeat (3) @(posedge mclk);
    rdck(32'hFFFF0330, 32'h0);
    src <= 32'h28;
    repeat (3) @(posedge mclk);
    rdck(32'hFFFF0330, c);
    src <= 32'h0;
  endtask

  // Time format on the crystal pin: carry, full scale, wraps
  task automatic t_time();
    axw(32'hFFFF0320, 32'h00003B63);
    axw(32'hFFFF0328, 32'h0);
    axw(32'hFFFF0328, 32'h3E0);
    pulse(0);
    rdck(32'hFFFF0324, 32'h00010000);
    axw(32'hFFFF0320, 32'h173B3B62);
    axw(32'hFFFF0328, 32'h0);
    axw(32'hFFFF0328, 32'h3E0);
    axw(32'hFFFF0328, 32'h3A0);
    pulse(0);
    rdck(32'hFFFF0324, 32'h173B3B63);
    check(i1, 1'b1);
    pulse(0);
    rdck(32'hFFFF0324, 32'h0);
    axw(32'hFFFF0328, 32'h0);
    axw(32'hFFFF0328, 32'h2B0);
    pulse(0);
    rdck(32'hFFFF0324, 32'hFF3B3B63);
    axw(32'hFFFF032C, 32'h0);
  endtask

  initial
  begin
    {mclk, rstn, awv, wv, bry, arv, rry, sel} = 8'h00;
    {pin, ws, awa, wd, ara, src} = '0;
    ws = 4'hF;
    num_errors = 0;
    checks_done = 0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_intervals();
    t_free_down();
    t_sources();
    t_capture();
    t_time();
    summarize();
  end
endmodule // testbench

`default_nettype wire
